// ### src/hfb_filter_bank.sv
// receive header filter bank: eight pattern/enable filters over the first 128 frame bits
// assumes register port and receive byte stream both on REF_CLK; frame bytes
// arrive in wire order, frame bit n is bit n%8 of byte n/8 (lsb first on the wire)
// and software leaves the tables alone while a header is coming in
`timescale 1ns/1ns
module hfb_filter_bank
   import hfb_pkg::*;
#(
   parameter bit FILTERS_PRESENT = 1'b1
)(
   input  wire logic        REF_CLK,
   input  wire logic        SYS_RST,
   input  wire logic [15:0] REG_ADDR,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   input  wire logic [31:0] REG_WDATA,
   output logic      [31:0] REG_RDATA,
   input  wire logic [7:0]  RX_DATA,
   input  wire logic        RX_VALID,
   input  wire logic        RX_SOF,
   input  wire logic        RX_EOF,
   output logic             RX_HIT_VALID,
   output logic             RX_HIT,
   output logic [7:0]       RX_HIT_MAP
);
   import hfb_pkg::*;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [NUM_FILTERS-1:0][HDR_BITS-1:0] pattern;
      logic [NUM_FILTERS-1:0][HDR_BITS-1:0] enable;
      logic [HDR_BITS-1:0]                  header;
      logic [3:0]                           byte_cnt;
      hfb_phase_type                        phase;
      logic [31:0]                          rdata;
      logic                                 hit_valid;
      logic                                 hit;
      logic [NUM_FILTERS-1:0]               hit_map;
   } hfb_state_type;

   hfb_state_type state;
   hfb_state_type next_state;

   logic                   in_bank;
   logic [2:0]             sel_filter;
   logic [2:0]             sel_word;
   logic [NUM_FILTERS-1:0] match;
   logic [HDR_BITS-1:0]    full_header;
   logic [15:0]            rel_addr;

   assign rel_addr    = REG_ADDR - FILTER_BASE;
   // below the base the subtraction wraps, so the lower bound is tested on its own
   // [R1] eight filters of eight aligned words each
   assign in_bank     = (REG_ADDR >= FILTER_BASE) && (rel_addr < BANK_SPAN)
                        && (REG_ADDR[1:0] == 2'h0);
   assign sel_filter  = rel_addr[7:5];
   assign sel_word    = rel_addr[4:2];
   // the sixteenth byte is compared as it arrives so the verdict comes one cycle sooner
   assign full_header = {RX_DATA, state.header[HDR_BITS-9:0]};

   // ------------------------------------------------------------
   // comparators
   // ------------------------------------------------------------
   // all eight compares run in parallel: more gates, but no extra cycle for the verdict
   genvar g;
   generate
      for (g = 0; g < NUM_FILTERS; g++) begin : g_cmp
         // [R6] a zero enable bit makes that bit don't-care
         // [R10] hit needs every enabled bit equal
         assign match[g] = ~|((full_header ^ state.pattern[g]) & state.enable[g]);
      end
   endgenerate

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_state           = state;
      next_state.hit_valid = 1'b0;
      // read data falls back to zero after one cycle so no stale word looks like an answer
      next_state.rdata     = 32'h00000000;
      // [R9] without filters every location reads zero
      if (REG_RD && in_bank && FILTERS_PRESENT) begin
         // [R2] [R3] [R4] [R5] [R6] words by offset
         if (sel_word < 3'(OFS_ENA0 >> 2)) begin
            next_state.rdata = state.pattern[sel_filter][sel_word[1:0]*32 +: 32];
         end else begin
            next_state.rdata = state.enable[sel_filter][sel_word[1:0]*32 +: 32];
         end
      end
      // a read in the same cycle as a write still returns the old word
      // [R9] writes silently dropped when filters absent
      if (REG_WR && in_bank && FILTERS_PRESENT) begin
         if (sel_word < 3'(OFS_ENA0 >> 2)) begin
            next_state.pattern[sel_filter][sel_word[1:0]*32 +: 32] = REG_WDATA;
         end else begin
            next_state.enable[sel_filter][sel_word[1:0]*32 +: 32] = REG_WDATA;
         end
      end
      // [R8] legacy receive header capture
      if (RX_VALID) begin
         case (state.phase)
            HFB_IDLE, HFB_BODY, HFB_HEADER: begin
               if (RX_SOF || state.phase == HFB_HEADER) begin
                  next_state.header[(RX_SOF ? 4'h0 : state.byte_cnt)*8 +: 8] = RX_DATA;
                  // the count wraps after the sixteenth byte; the body phase makes that harmless
                  next_state.byte_cnt = RX_SOF ? 4'h1 : state.byte_cnt + 4'h1;
                  next_state.phase    = HFB_HEADER;
                  // the tables are used as they stand when the sixteenth byte lands
                  if (!RX_SOF && state.byte_cnt == 4'(HDR_BYTES - 1)) begin
                     next_state.phase     = HFB_BODY;
                     next_state.hit_valid = 1'b1;
                     next_state.hit_map   = FILTERS_PRESENT ? match : '0;
                     next_state.hit       = FILTERS_PRESENT && (|match); // [R10]
                  end
               end
               if (RX_EOF && next_state.phase == HFB_HEADER) begin
                  // runt frame: no verdict, header never completed
                  next_state.phase = HFB_IDLE;
               end else if (RX_EOF) begin
                  next_state.phase = HFB_IDLE;
               end
            end
            default: next_state.phase = HFB_IDLE;
         endcase
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         // written tables fall back to their defaults on every reset
         for (int i = 0; i < NUM_FILTERS; i++) begin
            state.pattern[i] <= RST_PATTERN; // [R2] [R3] [R4] [R5]
            state.enable[i]  <= RST_ENABLE;  // [R7]
         end
         state.header    <= '0;
         state.byte_cnt  <= 4'h0;
         state.phase     <= HFB_IDLE;
         state.rdata     <= 32'h00000000;
         state.hit_valid <= 1'b0;
         state.hit       <= 1'b0;
         state.hit_map   <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign REG_RDATA    = state.rdata;
   assign RX_HIT_VALID = state.hit_valid;
   assign RX_HIT       = state.hit;
   assign RX_HIT_MAP   = state.hit_map;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_wr_pat0;
      REG_WR && in_bank && sel_word == 3'h0;
   endsequence

   // a read right behind a write to pattern word zero must return what was written, or zero in a build without filters
   a_write_readback: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [R2]
      (s_wr_pat0 ##1 (REG_RD && $past(REG_ADDR) == REG_ADDR && !REG_WR))
      |=> REG_RDATA == (FILTERS_PRESENT ? $past(REG_WDATA, 2) : 32'h00000000))
      else $error("pattern word did not read back");
   a_unmapped_zero: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [R9]
      !(REG_RD && in_bank) |=> REG_RDATA == 32'h00000000)
      else $error("read outside bank not zero");
   a_hit_any: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [R10]
      RX_HIT_VALID |-> RX_HIT == (|RX_HIT_MAP))
      else $error("hit does not follow map");
   a_hit_pulse: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [R8]
      RX_HIT_VALID |=> !RX_HIT_VALID)
      else $error("verdict longer than one cycle");

   sequence s_frame_start;
      RX_VALID && RX_SOF && !RX_EOF;
   endsequence

   sequence s_header_byte;
      RX_VALID && !RX_SOF && !RX_EOF;
   endsequence

   // the sixteenth byte may also be the last of the frame
   sequence s_last_byte;
      RX_VALID && !RX_SOF;
   endsequence

   sequence s_full_header;
      s_frame_start ##1 s_header_byte [*8] ##1 s_header_byte [*6] ##1 s_last_byte;
   endsequence

   // every filter must come back to its defaults, written ones included
   a_reset_dest: assert property (@(posedge REF_CLK) // [R7]
      $fell(SYS_RST) |-> state.enable == {NUM_FILTERS{RST_ENABLE}}
         && state.pattern == {NUM_FILTERS{RST_PATTERN}})
      else $error("reset values wrong");
   a_reset_outputs: assert property (@(posedge REF_CLK) // [R10]
      SYS_RST |=> !RX_HIT_VALID && !RX_HIT && RX_HIT_MAP == 8'h00
         && REG_RDATA == 32'h00000000)
      else $error("outputs not quiet after reset");
   // apart from reset, only an aligned write inside the bank of a build with filters touches the tables
   a_write_ignored: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [R9]
      !(REG_WR && in_bank && FILTERS_PRESENT)
         |=> $stable(state.pattern) && $stable(state.enable))
      else $error("filter table changed without a write");
   a_verdict_time: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [R10]
      s_full_header |=> RX_HIT_VALID)
      else $error("verdict not after sixteenth byte");
   a_runt_silent: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [R10]
      (RX_VALID && RX_EOF && !RX_SOF && state.phase == HFB_HEADER
         && state.byte_cnt != 4'(HDR_BYTES - 1)) |=> !RX_HIT_VALID)
      else $error("runt frame gave a verdict");
   a_sof_restart: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [R10]
      s_frame_start |=> state.phase == HFB_HEADER && state.byte_cnt == 4'h1)
      else $error("start of frame did not restart capture");
   // apart from reset, a new verdict is the only thing that may move the hit outputs
   a_map_held: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // [R10]
      !RX_HIT_VALID && !$past(SYS_RST) |-> $stable(RX_HIT_MAP) && $stable(RX_HIT))
      else $error("verdict changed between frames");
endmodule : hfb_filter_bank

// ### src/hfb_pkg.sv
// constants for the receive header filter bank
// assumes a simple register port clocked by REF_CLK and a byte stream from the mac receiver
//
// Contract
// [R1] eight filters, base 0x3000, stride 0x20
// [R2] pattern word0: destination bits 31..0, resets ones
// [R3] pattern word1 at 0x4, resets 0x0000FFFF
// [R4] pattern word2 at 0x8, resets zero
// [R5] pattern word3 at 0xC: vlan or type
// [R6] enable words 0x10..0x1C, one means compare
// [R7] enable resets: ones, 0xFFFF, zero, zero
// [R8] filters sit in legacy receive path
// [R9] absent filters read zero, ignore writes
// [R10] hit when all enabled bits match; any
package hfb_pkg;
   localparam int         NUM_FILTERS  = 8;
   localparam int         HDR_BITS     = 128;
   localparam int         HDR_BYTES    = 16;
   localparam logic [15:0] FILTER_BASE  = 16'h3000;
   localparam logic [15:0] FILTER_STEP  = 16'h0020;
   localparam logic [15:0] BANK_SPAN    = 16'h0100;
   localparam logic [4:0]  OFS_PAT0     = 5'h00;
   localparam logic [4:0]  OFS_PAT1     = 5'h04;
   localparam logic [4:0]  OFS_PAT2     = 5'h08;
   localparam logic [4:0]  OFS_PAT3     = 5'h0C;
   localparam logic [4:0]  OFS_ENA0     = 5'h10;
   localparam logic [4:0]  OFS_ENA3     = 5'h1C;
   localparam logic [31:0] RST_PAT0     = 32'hFFFFFFFF;
   localparam logic [31:0] RST_PAT1     = 32'h0000FFFF;
   localparam logic [31:0] RST_PAT2     = 32'h00000000;
   localparam logic [31:0] RST_PAT3     = 32'h00000000;
   localparam logic [31:0] RST_ENA0     = 32'hFFFFFFFF;
   localparam logic [31:0] RST_ENA1     = 32'h0000FFFF;
   localparam logic [31:0] RST_ENA2     = 32'h00000000;
   localparam logic [31:0] RST_ENA3     = 32'h00000000;
   localparam logic [127:0] RST_PATTERN = {RST_PAT3, RST_PAT2, RST_PAT1, RST_PAT0};
   localparam logic [127:0] RST_ENABLE  = {RST_ENA3, RST_ENA2, RST_ENA1, RST_ENA0};

   typedef enum logic [1:0] {HFB_IDLE, HFB_HEADER, HFB_BODY} hfb_phase_type;
endpackage : hfb_pkg

// ### dv/hfb_rx_source.sv
// stand-in for the mac receiver feeding legacy frames, one byte per edge
// assumes the bench calls send; the data lines are scrambled between frames
`timescale 1ns/1ns
module hfb_rx_source (
   input  wire logic       REF_CLK,
   output logic      [7:0] RX_DATA,
   output logic            RX_VALID,
   output logic            RX_SOF,
   output logic            RX_EOF
);
   initial begin
      RX_DATA  = 8'hA5;
      RX_VALID = 1'b0;
      RX_SOF   = 1'b0;
      RX_EOF   = 1'b0;
   end
   // frame bit n travels as bit n%8 of byte n/8; bytes past the header are filler
   task automatic send(input logic [127:0] hdr, input int len);
      for (int i = 0; i < len; i++) begin
         @(posedge REF_CLK) #1;
         RX_VALID = 1'b1;
         RX_SOF   = (i == 0);
         RX_EOF   = (i == len - 1);
         RX_DATA  = (i < 16) ? hdr[8*i +: 8] : 8'h5A;
      end
      @(posedge REF_CLK) #1;
      RX_VALID = 1'b0;
      RX_SOF   = 1'b0;
      RX_EOF   = 1'b0;
      // inverted so a stale byte can never pass for a held value
      RX_DATA  = ~RX_DATA;
   endtask : send
endmodule : hfb_rx_source

// ### dv/hfb_filter_bank_bench.sv
// bench for the header filter bank: register defaults, programming, frame verdicts
// assumes hfb_rx_source plays the receiver; a second bank is built without filters
`timescale 1ns/1ns
module hfb_filter_bank_bench;
   import hfb_pkg::*;
   logic        REF_CLK = 1'b0;
   logic        SYS_RST = 1'b1;
   logic [15:0] REG_ADDR = 16'h0000;
   logic        REG_WR = 1'b0;
   logic        REG_RD = 1'b0;
   logic [31:0] REG_WDATA = 32'h0;
   logic [31:0] REG_RDATA, rd_none;
   logic [7:0]  RX_DATA, RX_HIT_MAP;
   logic        RX_VALID, RX_SOF, RX_EOF, RX_HIT_VALID, RX_HIT;
   int          fail_count = 0, total_checks = 0, cycles = 0;
   typedef struct {logic [127:0] hdr; logic [7:0] map;} hfb_row_type;
   hfb_row_type rows [5] = '{'{128'hFFFFFFFFFFFF, 8'hD7}, '{128'h665544332211, 8'h08},
      '{128'hFEFFFFFFFFFF, 8'h00}, '{128'hABCD0888_00000000_00000000_00000123, 8'h20},
      '{128'h888_00000000_00006655_44332211, 8'h28}};
   logic [31:0] rst_tab [8] = '{32'hFFFFFFFF, 32'h0000FFFF, 32'h0, 32'h0,
      32'hFFFFFFFF, 32'h0000FFFF, 32'h0, 32'h0};
   always #20 REF_CLK = ~REF_CLK;
   hfb_rx_source src (.REF_CLK, .RX_DATA, .RX_VALID, .RX_SOF, .RX_EOF);
   hfb_filter_bank dut (.REF_CLK, .SYS_RST, .REG_ADDR, .REG_WR, .REG_RD, .REG_WDATA,
      .REG_RDATA, .RX_DATA, .RX_VALID, .RX_SOF, .RX_EOF, .RX_HIT_VALID, .RX_HIT, .RX_HIT_MAP);
   hfb_filter_bank #(.FILTERS_PRESENT(1'b0)) dut_none (.REF_CLK, .SYS_RST, .REG_ADDR,
      .REG_WR, .REG_RD, .REG_WDATA, .REG_RDATA(rd_none), .RX_DATA, .RX_VALID, .RX_SOF,
      .RX_EOF, .RX_HIT_VALID(), .RX_HIT(), .RX_HIT_MAP());
   task automatic check(input string nm, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge REF_CLK) #1;
      REG_ADDR  = a;
      REG_WDATA = d;
      REG_WR    = 1'b1;
      @(posedge REF_CLK) #1;
      REG_WR    = 1'b0;
   endtask : wr
   // every read also proves the filterless build returns zero, writes included
   task automatic rd(input logic [15:0] a, input logic [31:0] exp);
      @(posedge REF_CLK) #1;
      REG_ADDR = a;
      REG_RD   = 1'b1;
      @(posedge REF_CLK) #1;
      REG_RD   = 1'b0;
      check("rdata", REG_RDATA, exp);
      check("rdata_none", rd_none, 32'h0);
   endtask : rd
   // a read right behind the write, the case the readback check in the design guards
   task automatic wr_rd(input logic [15:0] a, input logic [31:0] d);
      @(posedge REF_CLK) #1;
      REG_ADDR  = a;
      REG_WDATA = d;
      REG_WR    = 1'b1;
      @(posedge REF_CLK) #1;
      REG_WR    = 1'b0;
      REG_RD    = 1'b1;
      @(posedge REF_CLK) #1;
      REG_RD    = 1'b0;
      check("wr_rd", REG_RDATA, d);
      check("wr_rd_none", rd_none, 32'h0);
   endtask : wr_rd
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : stop_test
   always @(posedge REF_CLK) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         stop_test();
      end
   end
   initial begin
      repeat (12) @(posedge REF_CLK);
      #1 SYS_RST = 1'b0;
      for (int w = 0; w < 8; w++) begin
         rd(16'h30E0 + 16'(4 * w), rst_tab[w]);
      end
      wr(16'h3060, 32'h44332211);
      wr(16'h3064, 32'h00006655);
      wr(16'h30B0, 32'h0);
      wr(16'h30B4, 32'h0);
      wr(16'h30AC, 32'h00000888);
      wr(16'h30BC, 32'h0000FFFF);
      rd(16'h3064, 32'h00006655);
      rd(16'h30AC, 32'h00000888);
      rd(16'h30AE, 32'h0);
      rd(16'h3100, 32'h0);
      foreach (rows[i]) begin
         src.send(rows[i].hdr, 16);
         check("hit_valid", 32'(RX_HIT_VALID), 32'h1);
         check("hit_map", 32'(RX_HIT_MAP), 32'(rows[i].map));
         check("hit", 32'(RX_HIT), 32'(|rows[i].map));
      end
      // a runt frame must leave the last verdict standing
      src.send(128'hFFFFFFFFFFFF, 10);
      repeat (6) begin
         check("runt_verdict", 32'(RX_HIT_VALID), 32'h0);
         @(posedge REF_CLK) #1;
      end
      check("map_held", 32'(RX_HIT_MAP), 32'h28);
      SYS_RST = 1'b1;
      @(posedge REF_CLK) #1;
      SYS_RST = 1'b0;
      check("map_reset", 32'(RX_HIT_MAP), 32'h0);
      rd(16'h3060, 32'hFFFFFFFF);
      rd(16'h30BC, 32'h0);
      wr_rd(16'h3040, 32'h5A5AA5A5);
      stop_test();
   end
endmodule : hfb_filter_bank_bench
